// ### vsc_pkg.sv
// Purpose: shared constants and types of the slot-one system controller
// Assumes: 100 MHz core clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
package vsc_pkg;
  // ----------------------------------------
  // clocking and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SYSCLK_MHZ = 16;
  localparam int GNT_TMO_US = 16;
  localparam int GNT_TMO_CYC = GNT_TMO_US * CLK_MHZ;
  localparam int GNT_CNT_W = $clog2(GNT_TMO_CYC);
  localparam logic [GNT_CNT_W-1:0] GNT_CNT_MAX = GNT_CNT_W'(GNT_TMO_CYC - 1);
  localparam int DETECT_MS = 40;
  localparam int DETECT_CYC = DETECT_MS * 1000 * CLK_MHZ;
  localparam int PRE_W = $clog2(CLK_MHZ);
  localparam logic [PRE_W-1:0] PRE_MAX = PRE_W'(CLK_MHZ - 1);
  localparam int RST_STRETCH_CYC = 16;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_STEP = DIV_W'(2 * SYSCLK_MHZ);
  localparam logic [DIV_W-1:0] DIV_MOD = DIV_W'(CLK_MHZ);
  // ----------------------------------------
  // arbitration levels
  // ----------------------------------------
  localparam int LVL_N = 4;
  localparam int LVL_W = 2;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
  localparam logic [LVL_N-1:0] LVL_NONE_N = 4'hf;
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_GRANT = 2'b01,
    ARB_BUSY = 2'b10
  } vsc_arb_state_t;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BTMO = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_BSET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_BCLR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_FORCE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
  localparam int CTRL_RR = 0;
  localparam int CTRL_SRST = 1;
  localparam int CTRL_PFE = 2;
  localparam int BIT_SFAIL = 0;
  localparam int ST_ROLE = 0;
  localparam int ST_ATMO = 1;
  localparam int ST_SFAIL = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_OWN = 4;
  localparam int ST_BERR = 6;
  localparam int TMO_W = 8;
  localparam logic [TMO_W-1:0] BTMO_RST = 8'h40;
  // ----------------------------------------
  // synchronised pin vector
  // ----------------------------------------
  localparam int SYNC_W = 13;
  // straps settle to off, active-low bus lines to released
  localparam logic [SYNC_W-1:0] SYNC_RST = 13'h7ff;
  localparam int SI_BR = 0;
  localparam int SI_BBSY = 4;
  localparam int SI_DS = 5;
  localparam int SI_DTACK = 7;
  localparam int SI_BERR = 8;
  localparam int SI_ACF = 9;
  localparam int SI_GIN = 10;
  localparam int SI_AUTO = 11;
  localparam int SI_STAT = 12;
endpackage

// ### vsc_tmr_if.sv
// Purpose: link between controller and bus timer
// Assumes: one clock domain
// Notes: run clears the count when low
interface vsc_tmr_if;
  logic run;
  logic [vsc_pkg::TMO_W-1:0] limit;
  logic expired;
  modport ctl (output run, output limit, input expired);
  modport tmr (input run, input limit, output expired);
endinterface

// ### vsc_sync.sv
// Purpose: two-flop synchroniser for pins
// Assumes: inputs asynchronous to clk
// Notes: reset value chosen per bit
module vsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### vsc_bus_timer.sv
// Purpose: microsecond bus timer for stalled data strobes
// Assumes: run held while the strobe is pending
// Notes: a limit of zero never expires
module vsc_bus_timer (
  input wire logic clk,
  input wire logic rstn,
  vsc_tmr_if.tmr tif
);
  import vsc_pkg::*;
  logic [PRE_W-1:0] pre_q;
  logic [TMO_W-1:0] us_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      us_q <= '0;
    end else if (!tif.run) begin
      pre_q <= '0;
      us_q <= '0;
    end else if (pre_q == PRE_MAX) begin
      pre_q <= '0;
      if (!tif.expired) begin
        us_q <= us_q + 1'b1;
      end
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tif.expired <= 1'b0;
    end else begin
      tif.expired <= tif.run && (tif.limit != '0) && (us_q >= tif.limit);
    end
  end
endmodule

// ### vsc_sysctl.sv
// Purpose: slot-one system controller: arbiter, bus timer, clock, reset, fail drivers
// Assumes: por_n is power-on only; rstn is the board hardware reset
// Notes: role (unless set by auto detection), clock and reset drivers survive board reset; por_n clears them
// Notes on behaviour
// - controller duties only while this board acts as slot-one controller.
// - fixed priority grants highest pending level, from level 3 to 0.
// - fixed priority asserts bus clear when a higher level requests.
// - round robin scans levels 3 toward 0, one grant per level each pass.
// - grant withdrawn and timeout status set if busy absent for 16 us.
// - bus timer runs from data strobe until acknowledge or bus error.
// - timer beyond programmed microseconds drives bus error to abort cycle.
// - system clock of 16 MHz runs continuously, also during reset.
// - system clock output disabled when not controller.
// - system reset driven only while controller.
// - software reset bit drives system reset.
// - local hardware reset drives system reset.
// - power fail drives system reset only when enabled.
// - fail line set through bit-set and released through bit-clear.
// - active-low user fail indicator follows the fail state.
// - build parameter chooses fail line state after reset.
// - fail line asserted at reset stays until software clears it.
// - fail line driven regardless of controller role.
// - slot detection used only when auto strap is one.
// - grant-in level 3 sampled 40 ms after reset; low makes controller.
// - force command makes the board controller regardless of detection.
// - strap zero: static strap or force command decides role.
//
// Implementation choices: the register offsets and the APB interface to the registers.
module vsc_sysctl #(
  parameter int DETECT_CNT = vsc_pkg::DETECT_CYC,
  parameter bit SYSFAIL_MODE = 1'b0,
  parameter int RST_STRETCH = vsc_pkg::RST_STRETCH_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [vsc_pkg::LVL_N-1:0] br_sense_n,
  input wire logic bbsy_sense_n,
  output logic [vsc_pkg::LVL_N-1:0] bg_drive_n,
  output logic bclr_drive_n,
  input wire logic [1:0] ds_sense_n,
  input wire logic dtack_sense_n,
  input wire logic berr_sense_n,
  output logic berr_val,
  output logic berr_en,
  input wire logic acfail_sense_n,
  output logic sysclk_val,
  output logic sysclk_en,
  output logic sysreset_val,
  output logic sysreset_en,
  output logic sysfail_val,
  output logic sysfail_en,
  output logic user_sysfail_n,
  input wire logic grant_in_n,
  input wire logic auto_slot_detect_strap,
  input wire logic static_controller_strap
);
  import vsc_pkg::*;
  localparam int DET_W = $clog2(DETECT_CNT + 1);
  localparam int STR_W = $clog2(RST_STRETCH + 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic rstn_s;
  vsc_sync #(.W(SYNC_W), .RST_VAL(SYNC_RST)) u_pin_sync (
    .clk(clk),
    .rstn(por_n),
    .d({static_controller_strap, auto_slot_detect_strap, grant_in_n, acfail_sense_n,
        berr_sense_n, dtack_sense_n, ds_sense_n, bbsy_sense_n, br_sense_n}),
    .q(pins_s)
  );
  // local reset seen as a level so it can drive the backplane reset
  vsc_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk(clk),
    .rstn(por_n),
    .d(rstn),
    .q(rstn_s)
  );
  logic [LVL_N-1:0] req;
  logic bbsy_n_s, ds_act, dtack_n_s, berr_n_s, acfail_n_s, auto_s, static_s, gin_n_s;
  assign req = ~pins_s[SI_BR +: LVL_N];
  assign bbsy_n_s = pins_s[SI_BBSY];
  assign ds_act = ~&pins_s[SI_DS +: 2];
  assign dtack_n_s = pins_s[SI_DTACK];
  assign berr_n_s = pins_s[SI_BERR];
  assign acfail_n_s = pins_s[SI_ACF];
  assign gin_n_s = pins_s[SI_GIN];
  assign auto_s = pins_s[SI_AUTO];
  assign static_s = pins_s[SI_STAT];

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic rr_q, soft_q, pfe_q, sfail_q, forced_q, role_q, atmo_q;
  logic [TMO_W-1:0] btmo_q;
  logic acc, wr_evt, hit;
  logic [31:0] rd_val;
  logic [LVL_W-1:0] owner_q;
  vsc_arb_state_t state_q;
  assign acc = psel && penable && !pready;
  assign wr_evt = psel && penable && pready && pwrite;
  always_comb begin
    rd_val = '0;
    hit = 1'b1;
    unique case (paddr)
      OFF_CTRL: begin
        rd_val[CTRL_RR] = rr_q;
        rd_val[CTRL_SRST] = soft_q;
        rd_val[CTRL_PFE] = pfe_q;
      end
      OFF_BTMO: rd_val[TMO_W-1:0] = btmo_q;
      OFF_BSET, OFF_BCLR: rd_val[BIT_SFAIL] = sfail_q;
      OFF_FORCE: rd_val = '0;
      OFF_STAT: begin
        rd_val[ST_ROLE] = role_q;
        rd_val[ST_ATMO] = atmo_q;
        rd_val[ST_SFAIL] = sfail_q;
        rd_val[ST_BUSY] = (state_q == ARB_BUSY);
        rd_val[ST_OWN +: LVL_W] = owner_q;
        rd_val[ST_BERR] = berr_en;
      end
      default: hit = 1'b0;
    endcase
  end
  // answer one cycle into the access phase; writes land one edge later, as the transfer completes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= pwrite ? '0 : rd_val;
        pslverr <= !hit;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rr_q <= 1'b0;
      soft_q <= 1'b0;
      pfe_q <= 1'b0;
      btmo_q <= BTMO_RST;
    end else if (wr_evt && paddr == OFF_CTRL) begin
      rr_q <= pwdata[CTRL_RR];
      soft_q <= pwdata[CTRL_SRST];
      pfe_q <= pwdata[CTRL_PFE];
    end else if (wr_evt && paddr == OFF_BTMO) begin
      btmo_q <= pwdata[TMO_W-1:0];
    end
  end

  // ----------------------------------------
  // system fail driver
  // ----------------------------------------
  logic sfail_set, sfail_clr;
  assign sfail_set = wr_evt && paddr == OFF_BSET && pwdata[BIT_SFAIL];
  assign sfail_clr = wr_evt && paddr == OFF_BCLR && pwdata[BIT_SFAIL];
  // driven whatever the role; reset state is a build choice
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfail_q <= SYSFAIL_MODE;
      user_sysfail_n <= !SYSFAIL_MODE;
    end else if (sfail_set) begin
      sfail_q <= 1'b1;
      user_sysfail_n <= 1'b0;
    end else if (sfail_clr) begin
      sfail_q <= 1'b0;
      user_sysfail_n <= 1'b1;
    end
  end
  assign sysfail_en = sfail_q;
  assign sysfail_val = 1'b0;

  // ----------------------------------------
  // first slot detection and role
  // ----------------------------------------
  logic [DET_W-1:0] det_cnt_q;
  logic det_done_q, det_sc_q, det_fire;
  assign det_fire = !det_done_q && det_cnt_q == DET_W'(DETECT_CNT - 1);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      det_cnt_q <= '0;
      det_done_q <= 1'b0;
      det_sc_q <= 1'b0;
    end else if (det_fire) begin
      det_done_q <= 1'b1;
      det_sc_q <= !gin_n_s;
    end else if (!det_done_q) begin
      det_cnt_q <= det_cnt_q + 1'b1;
    end
  end
  // role survives board reset, except one set by auto detection, so the clock keeps running through it
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      forced_q <= 1'b0;
      role_q <= 1'b0;
    end else begin
      if (wr_evt && paddr == OFF_FORCE) begin
        forced_q <= 1'b1;
      end
      role_q <= forced_q || (auto_s ? det_sc_q : static_s);
    end
  end

  // ----------------------------------------
  // arbiter
  // ----------------------------------------
  function automatic logic [LVL_W-1:0] pick_lvl(input logic [LVL_N-1:0] r,
                                                input logic [LVL_W-1:0] start);
    logic [LVL_W-1:0] idx;
    logic [LVL_W-1:0] res;
    res = start;
    for (int i = LVL_N - 1; i >= 0; i--) begin
      idx = start - LVL_W'(i);
      if (r[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction
  logic [LVL_W-1:0] rr_ptr_q, pick;
  logic [GNT_CNT_W-1:0] gnt_cnt_q;
  logic higher, tmo_evt;
  assign pick = pick_lvl(req, rr_q ? rr_ptr_q : LVL_TOP);
  assign higher = |(req & ~((4'h2 << owner_q) - 4'h1));
  assign tmo_evt = role_q && state_q == ARB_GRANT && bbsy_n_s && gnt_cnt_q == GNT_CNT_MAX;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ARB_IDLE;
      owner_q <= '0;
      gnt_cnt_q <= '0;
      bg_drive_n <= LVL_NONE_N;
      rr_ptr_q <= LVL_TOP;
    end else if (!role_q) begin
      state_q <= ARB_IDLE;
      bg_drive_n <= LVL_NONE_N;
      gnt_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ARB_IDLE: begin
          if (|req) begin
            owner_q <= pick;
            bg_drive_n <= ~(4'h1 << pick);
            gnt_cnt_q <= '0;
            state_q <= ARB_GRANT;
          end
        end
        ARB_GRANT: begin
          if (!bbsy_n_s) begin
            bg_drive_n <= LVL_NONE_N;
            rr_ptr_q <= owner_q - 1'b1;
            state_q <= ARB_BUSY;
          end else if (gnt_cnt_q == GNT_CNT_MAX) begin
            bg_drive_n <= LVL_NONE_N;
            state_q <= ARB_IDLE;
          end else begin
            gnt_cnt_q <= gnt_cnt_q + 1'b1;
          end
        end
        ARB_BUSY: begin
          if (bbsy_n_s) begin
            state_q <= ARB_IDLE;
          end
        end
        default: state_q <= ARB_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bclr_drive_n <= 1'b1;
    end else begin
      bclr_drive_n <= !(role_q && !rr_q && state_q == ARB_BUSY && higher);
    end
  end
  // a new timeout beats a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      atmo_q <= 1'b0;
    end else if (tmo_evt) begin
      atmo_q <= 1'b1;
    end else if (wr_evt && paddr == OFF_STAT && pwdata[ST_ATMO]) begin
      atmo_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // bus timer
  // ----------------------------------------
  vsc_tmr_if tif ();
  // own bus error must not stop the count that caused it
  assign tif.run = role_q && ds_act && dtack_n_s && (berr_n_s || berr_en);
  assign tif.limit = btmo_q;
  vsc_bus_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .tif(tif)
  );
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      berr_en <= 1'b0;
    end else begin
      berr_en <= role_q && ds_act && tif.expired;
    end
  end
  assign berr_val = 1'b0;

  // ----------------------------------------
  // clock and reset drivers
  // ----------------------------------------
  // fractional divider: 16 MHz on average, edges jitter by one core cycle
  logic [DIV_W-1:0] div_q, div_sum;
  assign div_sum = div_q + DIV_STEP;
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      div_q <= '0;
      sysclk_val <= 1'b0;
      sysclk_en <= 1'b0;
    end else begin
      if (div_sum >= DIV_MOD) begin
        div_q <= div_sum - DIV_MOD;
        sysclk_val <= !sysclk_val;
      end else begin
        div_q <= div_sum;
      end
      sysclk_en <= role_q;
    end
  end
  logic [STR_W-1:0] str_q;
  logic hw_rst;
  assign hw_rst = !rstn_s || str_q != '0;
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      str_q <= '0;
      sysreset_en <= 1'b0;
    end else begin
      if (!rstn_s) begin
        str_q <= STR_W'(RST_STRETCH);
      end else if (str_q != '0) begin
        str_q <= str_q - 1'b1;
      end
      sysreset_en <= role_q && (hw_rst || soft_q || (pfe_q && !acfail_n_s));
    end
  end
  assign sysreset_val = 1'b0;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  fixed_prio_pick_a: assert property ((state_q == ARB_IDLE && role_q && |req && !rr_q) |=>
    ($past(req) & ~((4'h2 << owner_q) - 4'h1)) == 4'h0) else $error("lower level granted");
  bclr_higher_a: assert property ((role_q && !rr_q && state_q == ARB_BUSY && higher) |=>
    !bclr_drive_n) else $error("bus clear missing");
  rr_rotate_a: assert property ((role_q && rr_q && state_q == ARB_GRANT && !bbsy_n_s) |=>
    rr_ptr_q == owner_q - 2'h1) else $error("round robin did not rotate");
  grant_tmo_a: assert property (tmo_evt |=> bg_drive_n == LVL_NONE_N && atmo_q &&
    state_q == ARB_IDLE) else $error("grant timeout mishandled");
  berr_cause_a: assert property ($rose(berr_en) |-> $past(tif.expired && role_q))
    else $error("bus error without expiry");
  soft_reset_a: assert property ((role_q && (soft_q || (pfe_q && !acfail_n_s))) |=>
    sysreset_en) else $error("system reset not driven");
  no_acfail_rst_a: assert property ((!pfe_q && !soft_q && !hw_rst) |=> !sysreset_en)
    else $error("reset driven without cause");
  sysfail_set_a: assert property (sfail_set |=> sysfail_en && !user_sysfail_n)
    else $error("fail line not set");
  force_role_a: assert property ((wr_evt && paddr == OFF_FORCE) |=> ##1 role_q)
    else $error("force did not take role");
  released_a: assert property (!role_q [*2] |-> bg_drive_n == LVL_NONE_N && bclr_drive_n &&
    !berr_en && !sysreset_en && !sysclk_en) else $error("driver active off role");
  cv_grant_c: cover property (state_q == ARB_GRANT ##1 state_q == ARB_BUSY);
  cv_tmo_c: cover property (tmo_evt);
  cv_berr_c: cover property ($rose(berr_en));
  cv_detect_c: cover property (det_fire && !gin_n_s && auto_s);
endmodule

// ### vsc_vme_partner.sv
// Purpose: other backplane boards that request and use the bus
// Assumes: one request per level; busy taken at once or never
// Notes: request and busy lines have pull-ups, so released reads high
module vsc_vme_partner (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] req_add,
  input wire logic answer,
  input wire logic [7:0] hold_cyc,
  input wire logic [3:0] bg_drive_n,
  input wire logic bclr_drive_n,
  output logic [3:0] br_sense_n,
  output logic bbsy_sense_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pend_q;
  logic [3:0] nxt;
  logic [7:0] cnt_q;
  assign br_sense_n = ~pend_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 4'h0;
      cnt_q <= 8'h0;
      bbsy_sense_n <= 1'b1;
    end else begin
      nxt = pend_q | req_add;
      if (!bbsy_sense_n) begin
        cnt_q <= cnt_q + 8'h1;
        // yield on bus clear only once the arbiter has surely seen busy
        if (cnt_q >= hold_cyc || (!bclr_drive_n && cnt_q >= 8'h4)) begin
          bbsy_sense_n <= 1'b1;
        end
      end else begin
        for (int l = 0; l < 4; l++) begin
          if (!bg_drive_n[l] && pend_q[l]) begin
            nxt[l] = 1'b0;
            cnt_q <= 8'h0;
            bbsy_sense_n <= !answer;
          end
        end
      end
      pend_q <= nxt;
    end
  end
endmodule

// ### vsc_sysctl_test.sv
// Purpose: self-checking bench of the slot-one system controller
// Assumes: short detection and stretch counts
// Notes: reads and grants are checked from queues by monitors
module vsc_sysctl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import vsc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} vsc_rd_t;
  logic clk, rstn, por_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic bbsy_sense_n, bclr_drive_n, dtack_sense_n, berr_sense_n, berr_en;
  logic acfail_sense_n, sysclk_val, sysclk_en, sysreset_en, sysfail_en, user_sysfail_n;
  logic grant_in_n, auto_slot_detect_strap, static_controller_strap, answer;
  logic [3:0] br_sense_n, bg_drive_n, req_add, bg_prev;
  logic [3:0] tbl [4];
  logic [1:0] ds_sense_n;
  logic [7:0] hold_cyc;
  int err_total, n_tests, n, lim;
  int seed = 32'h2e5d0e72;
  vsc_rd_t rdq[$];
  logic [3:0] gq[$];
  vsc_sysctl #(.DETECT_CNT(50), .SYSFAIL_MODE(1'b0), .RST_STRETCH(4)) dut (
    .berr_val(), .sysreset_val(), .sysfail_val(), .*);
  vsc_vme_partner p (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // -----
  // checking
  // -----
  function automatic logic pin(input int s);
    case (s)
      0: return sysreset_en;
      1: return berr_en;
      2: return bclr_drive_n;
      3: return sysfail_en;
      4: return user_sysfail_n;
      5: return sysclk_en;
      6: return bg_drive_n[1];
      default: return &bg_drive_n;
    endcase
  endfunction
  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e, input string m);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_rd(input vsc_rd_t x);
    chk_pin({31'h0, pslverr}, {31'h0, x.e}, "read error flag");
    chk_pin(prdata & x.m, x.d, "read data");
  endtask
  task automatic chk_gnt(input logic [3:0] e);
    chk_pin({28'h0, bg_drive_n}, {28'h0, e}, "grant");
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk_rd(rdq.pop_front());
    if (bg_drive_n !== 4'hf && bg_prev === 4'hf) chk_gnt(gq.size() > 0 ? gq.pop_front() : 4'h0);
    bg_prev <= bg_drive_n;
  end
  // -----
  // drivers
  // -----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no local limit: only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
      k++;
    end
    chk_pin(k, 32'h1, "bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic e);
    rdq.push_back('{d, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wt(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (pin(s) !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk_pin({31'h0, pin(s)}, {31'h0, v}, "pin level");
  endtask
  task automatic hold(input int s, input logic v, input int cyc);
    logic ok;
    ok = 1'b1;
    repeat (cyc) begin
      @(posedge clk);
      ok &= (pin(s) === v);
    end
    chk_pin({31'h0, ok}, 32'h1, "pin held");
  endtask
  task automatic clk_cnt();
    int t;
    logic q;
    t = 0;
    q = sysclk_val;
    repeat (100) begin
      @(posedge clk);
      t += (sysclk_val !== q);
      q = sysclk_val;
    end
    chk_pin({31'h0, t inside {[31:33]}}, 32'h1, "clock rate");
  endtask
  task automatic req(input logic [3:0] m);
    req_add <= m;
    @(posedge clk);
    req_add <= 4'h0;
  endtask
  task automatic do_por(input logic a, input logic g, input logic s);
    por_n <= 1'b0;
    rstn <= 1'b0;
    auto_slot_detect_strap <= a;
    grant_in_n <= g;
    static_controller_strap <= s;
    repeat (4) @(posedge clk);
    por_n <= 1'b1;
    rstn <= 1'b1;
    repeat (80) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog well beyond the at most roughly 4000 cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    {psel, penable, pwrite, rstn, por_n, answer} = 6'h7;
    {paddr, pwdata, req_add, bg_prev, hold_cyc} = {40'h0, 4'h0, 4'hf, 8'hc};
    {ds_sense_n, dtack_sense_n, berr_sense_n, acfail_sense_n, grant_in_n} = 6'h3f;
    {auto_slot_detect_strap, static_controller_strap} = 2'h0;
    tbl = '{4'he, 4'h9, 4'h7, 4'h4};
    for (int i = 0; i < 4; i++) begin
      do_por(tbl[i][3], tbl[i][2], tbl[i][1]);
      rd(OFF_STAT, 32'h1, {31'h0, tbl[i][0]}, 1'b0);
    end
    chk_pin({31'h0, sysfail_en}, 32'h0, "fail after reset");
    rd(OFF_BTMO, 32'hff, 32'h40, 1'b0);
    rd(8'h18, 32'hffffffff, 32'h0, 1'b1);
    wr(OFF_BSET, 32'h1);
    wt(3, 1'b1, 3, n);
    wt(4, 1'b0, 3, n);
    rd(OFF_BCLR, 32'h1, 32'h1, 1'b0);
    wr(OFF_BCLR, 32'h1);
    wt(3, 1'b0, 3, n);
    wt(4, 1'b1, 3, n);
    wr(OFF_CTRL, 32'h2);
    hold(0, 1'b0, 10);
    wr(OFF_CTRL, 32'h0);
    chk_pin({31'h0, sysclk_en}, 32'h0, "clock off");
    req(4'h4);
    hold(7, 1'b1, 30);
    gq.push_back(4'hb);
    wr(OFF_FORCE, 32'h1);
    rd(OFF_STAT, 32'h1, 32'h1, 1'b0);
    repeat (40) @(posedge clk);
    wt(5, 1'b1, 5, n);
    clk_cnt();
    hold_cyc <= 8'd100;
    gq = '{4'h7, 4'hd, 4'hb};
    req(4'ha);
    wt(6, 1'b0, 300, n);
    req(4'h4);
    wt(2, 1'b0, 20, n);
    repeat (160) @(posedge clk);
    hold_cyc <= 8'd12;
    wr(OFF_CTRL, 32'h1);
    gq = '{4'hd, 4'he, 4'h7, 4'hb};
    req(4'hf);
    repeat (150) @(posedge clk);
    wr(OFF_CTRL, 32'h0);
    answer <= 1'b0;
    gq.push_back(4'he);
    req(4'h1);
    wt(7, 1'b0, 20, n);
    wt(7, 1'b1, 1700, n);
    chk_pin({31'h0, n inside {[1597:1602]}}, 32'h1, "grant hold");
    rd(OFF_STAT, 32'h2, 32'h2, 1'b0);
    wr(OFF_STAT, 32'h2);
    rd(OFF_STAT, 32'h2, 32'h0, 1'b0);
    answer <= 1'b1;
    lim = 1 + ($random(seed) & 3);
    wr(OFF_BTMO, lim);
    ds_sense_n <= 2'h0;
    wt(1, 1'b1, 600, n);
    chk_pin({31'h0, n inside {[lim * 100:lim * 100 + 6]}}, 32'h1, "timer span");
    ds_sense_n <= 2'h3;
    wt(1, 1'b0, 8, n);
    ds_sense_n <= 2'h1;
    repeat (lim * 100 - 30) @(posedge clk);
    dtack_sense_n <= 1'b0;
    hold(1, 1'b0, 80);
    {ds_sense_n, dtack_sense_n} <= 3'h7;
    wr(OFF_CTRL, 32'h2);
    wt(0, 1'b1, 6, n);
    wr(OFF_CTRL, 32'h0);
    wt(0, 1'b0, 6, n);
    acfail_sense_n <= 1'b0;
    hold(0, 1'b0, 10);
    wr(OFF_CTRL, 32'h4);
    wt(0, 1'b1, 6, n);
    acfail_sense_n <= 1'b1;
    wt(0, 1'b0, 12, n);
    rstn <= 1'b0;
    wt(0, 1'b1, 6, n);
    clk_cnt();
    rstn <= 1'b1;
    wt(0, 1'b0, 15, n);
    chk_pin(rdq.size() + gq.size(), 32'h0, "results left");
    end_sim();
  end
endmodule
